// >>> hw/tws_cond_detect.sv
`timescale 1ns/1ps
module tws_cond_detect (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstSyncN,
  // synchronised bus levels
  input  wire logic sclLevel,
  input  wire logic sdaLevel,
  // bus events, one cycle each
  output      logic sclRise,
  output      logic sclFall,
  output      logic startSeen,
  output      logic stopSeen
);

  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
  } tws_cond_t;

  tws_cond_t cur_ff;
  tws_cond_t nxt_cur;

  // ==========================================================================
  // sda moving while scl stays high marks START or STOP
  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.sclPrev = sclLevel;
    nxt_cur.sdaPrev = sdaLevel;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cur_ff <= '1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sclRise   = sclLevel & ~cur_ff.sclPrev;
  assign sclFall   = ~sclLevel & cur_ff.sclPrev;
  assign startSeen = sclLevel & cur_ff.sclPrev & cur_ff.sdaPrev & ~sdaLevel;
  assign stopSeen  = sclLevel & cur_ff.sclPrev & ~cur_ff.sdaPrev & sdaLevel;

endmodule : tws_cond_detect

// >>> hw/tws_pkg.sv
package tws_pkg;

  // ==========================================================================
  // register map, one aligned word each
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA   = 8'h08;
  localparam logic [7:0] ADDR_OWN    = 8'h0C;

  // ==========================================================================
  // interface_control bit positions
  localparam int CTRL_INT_FLAG  = 7;
  localparam int CTRL_ACK_EN    = 6;
  localparam int CTRL_START_REQ = 5;
  localparam int CTRL_STOP_REQ  = 4;
  localparam int CTRL_WCOL      = 3;
  localparam int CTRL_IF_EN     = 2;
  localparam int CTRL_INT_EN    = 0;

  // own_slave_address: upper seven bits address, bit 0 general call enable
  localparam int OWN_GC_EN      = 0;
  localparam logic [7:0] OWN_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hFF;

  // ==========================================================================
  // status codes, prescaler bits zero
  localparam logic [7:0] ST_RX_OWN     = 8'h60;
  localparam logic [7:0] ST_RX_OWN_AL  = 8'h68;
  localparam logic [7:0] ST_RX_GC      = 8'h70;
  localparam logic [7:0] ST_RX_GC_AL   = 8'h78;
  localparam logic [7:0] ST_RX_DATA    = 8'h80;
  localparam logic [7:0] ST_RX_NACK    = 8'h88;
  localparam logic [7:0] ST_GC_DATA    = 8'h90;
  localparam logic [7:0] ST_GC_NACK    = 8'h98;
  localparam logic [7:0] ST_STOP       = 8'hA0;
  localparam logic [7:0] ST_TX_OWN     = 8'hA8;
  localparam logic [7:0] ST_TX_OWN_AL  = 8'hB0;
  localparam logic [7:0] ST_TX_ACK     = 8'hB8;
  localparam logic [7:0] ST_TX_NACK    = 8'hC0;
  localparam logic [7:0] ST_TX_LAST    = 8'hC8;
  localparam logic [7:0] ST_NO_INFO    = 8'hF8;
  localparam logic [6:0] GC_ADDRESS    = 7'h00;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_RX, SL_RX_ACK, SL_TX, SL_TX_ACK, SL_HOLD
  } tws_state_t;

endpackage : tws_pkg

// >>> hw/tws_slave_ctrl.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// Operation
// - general call data acked: 0x90, ack per enable
// - general call data nacked: 0x98, then unaddressed
// - stop or restart while addressed: 0xA0
// - start request on clear: queue START
// - unaddressed: recognition follows ack and gc enables
// - upper seven bits own address, bit0 gc
// - read bit selects transmit, else receive
// - address match sets flag and status
// - lost arbitration then own read: 0xB0
// - ack disabled: final byte, 0xC0 or 0xC8
// - after final byte, released, master reads ones
// - master ack after last byte gives 0xC8
// - ack disabled ignores address, keeps monitoring
// - deep sleep still acknowledges, requests wake
// - scl held low until flag cleared
// - data register not updated in deep sleep
// - own write address acked: 0x60
// - own read address acked: 0xA8
// - transmitted byte acked: 0xB8
module tws_slave_ctrl #(
  parameter int AW = 8
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output      logic [31:0]   prdata,
  output      logic          pready,
  output      logic          pslverr,
  // two-wire bus pins, open drain
  input  wire logic          sclIn,
  output      logic          sclOut,
  output      logic          sclOe,
  input  wire logic          sdaIn,
  output      logic          sdaOut,
  output      logic          sdaOe,
  // system side
  input  wire logic          deepSleep,
  input  wire logic          arbLost,
  output      logic          wakeReq,
  output      logic          masterStart
);

  typedef struct packed {
    tws_pkg::tws_state_t state;
    logic        intFlag;
    logic        ackEn;
    logic        startReq;
    logic        stopReq;
    logic        wcol;
    logic        ifEn;
    logic        intEn;
    logic [7:0]  ownAddr;
    logic [7:0]  dataReg;
    logic [1:0]  presc;
    logic [7:0]  code;
    logic [7:0]  shift;
    logic [3:0]  bitCnt;
    logic        genCall;
    logic        lastByte;
    logic        masterAck;
    logic        sdaDrive;
    logic        pendStart;
    logic        busFree;
    logic        wake;
    logic        startPulse;
    logic [31:0] rdata;
  } tws_ctrl_t;

  tws_ctrl_t   cur_ff;
  tws_ctrl_t   nxt_cur;
  logic [1:0]  rstPipe_ff;
  logic        rstSyncN;
  logic [1:0]  pinSync;
  logic        sclLevel;
  logic        sdaLevel;
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;
  logic        wrCycle;
  logic        swClear;
  logic [1:0]  match;

  // ==========================================================================
  // reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_ff[1];

  // ==========================================================================
  // pin sampling and bus conditions
  tws_sync #(.W(2)) uSync (
    .clk_sys (clk_sys), .rstSyncN (rstSyncN),
    .asyncIn ({sclIn, sdaIn}), .syncOut (pinSync)
  );
  assign sclLevel = pinSync[1];
  assign sdaLevel = pinSync[0];

  tws_cond_detect uCond (
    .clk_sys (clk_sys), .rstSyncN (rstSyncN), .sclLevel (sclLevel), .sdaLevel (sdaLevel),
    .sclRise (sclRise), .sclFall (sclFall), .startSeen (startSeen), .stopSeen (stopSeen)
  );

  // ==========================================================================
  // helpers
  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = a[7:0] inside {tws_pkg::ADDR_CTRL, tws_pkg::ADDR_STATUS, tws_pkg::ADDR_DATA,
                            tws_pkg::ADDR_OWN};
  endfunction : mapped
  // returns {own hit, general call hit}
  function automatic logic [1:0] addrHit(input logic [7:0] rx, input logic [7:0] own,
                                         input logic ack, input logic en);
    logic ownHit;
    logic gcHit;
    ownHit  = ack && en && (rx[7:1] == own[7:1]);
    gcHit   = ack && en && own[tws_pkg::OWN_GC_EN] && (rx[7:1] == tws_pkg::GC_ADDRESS)
              && !rx[0];
    addrHit = {ownHit, gcHit};
  endfunction : addrHit

  function automatic logic isTerm(input logic [7:0] c);
    isTerm = c inside {tws_pkg::ST_RX_NACK, tws_pkg::ST_GC_NACK, tws_pkg::ST_STOP,
                       tws_pkg::ST_TX_NACK, tws_pkg::ST_TX_LAST};
  endfunction : isTerm

  assign wrCycle = psel && penable && pwrite;
  assign swClear = wrCycle && (paddr[7:0] == tws_pkg::ADDR_CTRL) &&
                   pwdata[tws_pkg::CTRL_INT_FLAG];
  assign match   = addrHit(cur_ff.shift, cur_ff.ownAddr, cur_ff.ackEn, cur_ff.ifEn);

  // ==========================================================================
  // next state
  always_comb begin
    nxt_cur            = cur_ff;
    nxt_cur.startPulse = 1'b0;

    // register writes; they land before the engine so a clear sees new bits
    if (wrCycle) begin
      case (paddr[7:0])
        tws_pkg::ADDR_CTRL: begin
          nxt_cur.ackEn    = pwdata[tws_pkg::CTRL_ACK_EN];
          nxt_cur.startReq = pwdata[tws_pkg::CTRL_START_REQ];
          nxt_cur.stopReq  = pwdata[tws_pkg::CTRL_STOP_REQ];
          nxt_cur.ifEn     = pwdata[tws_pkg::CTRL_IF_EN];
          nxt_cur.intEn    = pwdata[tws_pkg::CTRL_INT_EN];
          if (swClear) begin
            nxt_cur.intFlag = 1'b0;
          end
        end
        tws_pkg::ADDR_STATUS: nxt_cur.presc = pwdata[1:0];
        tws_pkg::ADDR_DATA: begin
          // loading while the bus is live would corrupt the shift register
          if (cur_ff.intFlag) begin
            nxt_cur.dataReg = pwdata[7:0];
            nxt_cur.wcol    = 1'b0;
          end else begin
            nxt_cur.wcol = 1'b1;
          end
        end
        tws_pkg::ADDR_OWN: nxt_cur.ownAddr = pwdata[7:0];
        default: ;
      endcase
    end

    // read data registered in the setup cycle
    if (psel && !penable) begin
      case (paddr[7:0])
        tws_pkg::ADDR_CTRL:   nxt_cur.rdata = {24'h0, cur_ff.intFlag, cur_ff.ackEn,
                                               cur_ff.startReq, cur_ff.stopReq, cur_ff.wcol,
                                               cur_ff.ifEn, 1'b0, cur_ff.intEn};
        tws_pkg::ADDR_STATUS: nxt_cur.rdata = {24'h0,
                                               (cur_ff.intFlag ? cur_ff.code[7:3] :
                                                tws_pkg::ST_NO_INFO[7:3]),
                                               1'b0, cur_ff.presc};
        tws_pkg::ADDR_DATA:   nxt_cur.rdata = {24'h0, cur_ff.dataReg};
        tws_pkg::ADDR_OWN:    nxt_cur.rdata = {24'h0, cur_ff.ownAddr};
        default:              nxt_cur.rdata = 32'h0;
      endcase
    end

    if (startSeen) begin
      nxt_cur.busFree = 1'b0;
    end else if (stopSeen) begin
      nxt_cur.busFree = 1'b1;
    end
    if (!deepSleep) begin
      nxt_cur.wake = 1'b0;
    end

    // ========================================================================
    // slave engine
    case (cur_ff.state)
      tws_pkg::SL_IDLE: begin
        nxt_cur.sdaDrive = 1'b0;
        if (startSeen) begin
          nxt_cur.state  = tws_pkg::SL_ADDR;
          nxt_cur.bitCnt = 4'h0;
        end
      end
      tws_pkg::SL_ADDR: begin
        if (stopSeen) begin
          nxt_cur.state = tws_pkg::SL_IDLE;
        end else if (startSeen) begin
          nxt_cur.bitCnt = 4'h0;
        end else if (sclRise) begin
          nxt_cur.shift  = {cur_ff.shift[6:0], sdaLevel};
          nxt_cur.bitCnt = cur_ff.bitCnt + 4'h1;
        end else if (sclFall && cur_ff.bitCnt == tws_pkg::BITS_PER_BYTE) begin
          if (match != 2'b00) begin
            nxt_cur.sdaDrive = 1'b1;
            nxt_cur.genCall  = match[0] && !match[1];
            nxt_cur.state    = tws_pkg::SL_ADDR_ACK;
            if (deepSleep) begin
              nxt_cur.wake = 1'b1;
            end
          end else begin
            nxt_cur.state = tws_pkg::SL_IDLE;
          end
        end
      end
      tws_pkg::SL_ADDR_ACK: begin
        if (sclFall) begin
          nxt_cur.sdaDrive = 1'b0;
          nxt_cur.intFlag  = 1'b1;
          nxt_cur.state    = tws_pkg::SL_HOLD;
          if (cur_ff.shift[0]) begin
            nxt_cur.code = arbLost ? tws_pkg::ST_TX_OWN_AL : tws_pkg::ST_TX_OWN;
          end else if (cur_ff.genCall) begin
            nxt_cur.code = arbLost ? tws_pkg::ST_RX_GC_AL : tws_pkg::ST_RX_GC;
          end else begin
            nxt_cur.code = arbLost ? tws_pkg::ST_RX_OWN_AL : tws_pkg::ST_RX_OWN;
          end
        end
      end
      tws_pkg::SL_RX: begin
        if (sclRise) begin
          nxt_cur.shift  = {cur_ff.shift[6:0], sdaLevel};
          nxt_cur.bitCnt = cur_ff.bitCnt + 4'h1;
        end else if (sclFall && cur_ff.bitCnt == tws_pkg::BITS_PER_BYTE) begin
          nxt_cur.sdaDrive = cur_ff.ackEn;
          nxt_cur.lastByte = !cur_ff.ackEn;
          nxt_cur.state    = tws_pkg::SL_RX_ACK;
        end
      end
      tws_pkg::SL_RX_ACK: begin
        if (sclFall) begin
          nxt_cur.sdaDrive = 1'b0;
          nxt_cur.intFlag  = 1'b1;
          nxt_cur.state    = tws_pkg::SL_HOLD;
          if (!deepSleep) begin
            nxt_cur.dataReg = cur_ff.shift;
          end
          if (cur_ff.genCall) begin
            nxt_cur.code = cur_ff.lastByte ? tws_pkg::ST_GC_NACK : tws_pkg::ST_GC_DATA;
          end else begin
            nxt_cur.code = cur_ff.lastByte ? tws_pkg::ST_RX_NACK : tws_pkg::ST_RX_DATA;
          end
        end
      end
      tws_pkg::SL_TX: begin
        if (sclFall) begin
          if (cur_ff.bitCnt == tws_pkg::BITS_PER_BYTE) begin
            nxt_cur.sdaDrive = 1'b0;
            nxt_cur.state    = tws_pkg::SL_TX_ACK;
          end else begin
            nxt_cur.sdaDrive = !cur_ff.shift[6];
            nxt_cur.shift    = {cur_ff.shift[6:0], 1'b1};
            nxt_cur.bitCnt   = cur_ff.bitCnt + 4'h1;
          end
        end
      end
      tws_pkg::SL_TX_ACK: begin
        if (sclRise) begin
          nxt_cur.masterAck = !sdaLevel;
        end else if (sclFall) begin
          nxt_cur.intFlag = 1'b1;
          nxt_cur.state   = tws_pkg::SL_HOLD;
          if (!cur_ff.masterAck) begin
            nxt_cur.code = tws_pkg::ST_TX_NACK;
          end else if (cur_ff.lastByte) begin
            nxt_cur.code = tws_pkg::ST_TX_LAST;
          end else begin
            nxt_cur.code = tws_pkg::ST_TX_ACK;
          end
        end
      end
      tws_pkg::SL_HOLD: begin
        // bus waits here with scl low until software clears the flag
        if (swClear) begin
          nxt_cur.bitCnt = 4'h0;
          if (nxt_cur.stopReq) begin
            nxt_cur.stopReq = 1'b0;
            nxt_cur.state   = tws_pkg::SL_IDLE;
          end else if (isTerm(cur_ff.code)) begin
            nxt_cur.state     = tws_pkg::SL_IDLE;
            nxt_cur.pendStart = nxt_cur.startReq;
          end else if (cur_ff.code inside {tws_pkg::ST_TX_OWN, tws_pkg::ST_TX_OWN_AL,
                                           tws_pkg::ST_TX_ACK}) begin
            nxt_cur.shift    = nxt_cur.dataReg;
            nxt_cur.sdaDrive = !nxt_cur.dataReg[7];
            nxt_cur.lastByte = !nxt_cur.ackEn;
            nxt_cur.bitCnt   = 4'h1;
            nxt_cur.state    = tws_pkg::SL_TX;
          end else begin
            nxt_cur.state = tws_pkg::SL_RX;
          end
        end
      end
      default: nxt_cur.state = tws_pkg::SL_IDLE;
    endcase

    // bus conditions while addressed and not parked on software
    if ((startSeen || stopSeen) && cur_ff.state != tws_pkg::SL_IDLE &&
        cur_ff.state != tws_pkg::SL_ADDR && cur_ff.state != tws_pkg::SL_HOLD) begin
      nxt_cur.sdaDrive = 1'b0;
      nxt_cur.intFlag  = 1'b1;
      nxt_cur.code     = tws_pkg::ST_STOP;
      nxt_cur.state    = tws_pkg::SL_HOLD;
    end

    if (cur_ff.pendStart && nxt_cur.busFree) begin
      nxt_cur.pendStart  = 1'b0;
      nxt_cur.startReq   = 1'b0;
      nxt_cur.startPulse = 1'b1;
    end

    if (!nxt_cur.ifEn) begin
      nxt_cur.state    = tws_pkg::SL_IDLE;
      nxt_cur.sdaDrive = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cur_ff         <= '0;
      cur_ff.state   <= tws_pkg::SL_IDLE;
      cur_ff.ownAddr <= tws_pkg::OWN_RESET;
      cur_ff.dataReg <= tws_pkg::DATA_RESET;
      cur_ff.code    <= tws_pkg::ST_NO_INFO;
      cur_ff.busFree <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata      = cur_ff.rdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped(paddr);
  assign sclOut      = 1'b0;
  assign sclOe       = (cur_ff.state == tws_pkg::SL_HOLD) && cur_ff.intFlag;
  assign sdaOut      = 1'b0;
  assign sdaOe       = cur_ff.sdaDrive;
  assign wakeReq     = cur_ff.wake;
  assign masterStart = cur_ff.startPulse;

endmodule : tws_slave_ctrl

// >>> hw/tws_sync.sv
`timescale 1ns/1ps
module tws_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rstSyncN,
  // levels
  input  wire logic [W-1:0] asyncIn,
  output      logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tws_sync_t;

  tws_sync_t cur_ff;
  tws_sync_t nxt_cur;

  // ==========================================================================
  // first stage only feeds the second
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.meta   = asyncIn;
    nxt_cur.stable = cur_ff.meta;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cur_ff <= '1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign syncOut = cur_ff.stable;

endmodule : tws_sync

// >>> testbench/two_wire_slave_state_control_tb.sv
`timescale 1ns/1ps
module two_wire_slave_state_control_tb;
  // ==========================================================================
  // stimulus and wires
  logic        clk_sys, rst_n, psel, penable, pwrite, err, ack;
  logic [7:0]  paddr, rx;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, sclW, sdaW;
  logic        deepSleep, arbLost, wakeReq, masterStart, sclLow, sdaLow;
  int          fails, checked, starts;

  assign sclW = !(sclLow | sclOe);
  assign sdaW = !(sdaLow | sdaOe);

  tws_slave_ctrl #(.AW(8)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .deepSleep(deepSleep), .arbLost(arbLost), .wakeReq(wakeReq),
    .masterStart(masterStart)
  );
  tws_bus_master i_mst (.sclW(sclW), .sdaW(sdaW), .sclLow(sclLow), .sdaLow(sdaLow));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (masterStart === 1'b1) begin
      starts++;
    end
  end

  // ==========================================================================
  // tasks
  task finish_test;
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rd

  // status reads the no-information code until the flag rises
  task expSt(input logic [7:0] c);
    int n;
    n = 0;
    do begin
      apb(tws_pkg::ADDR_STATUS, 1'b0, 32'h0);
      n++;
    end while (q[7:0] === tws_pkg::ST_NO_INFO && n < 200);
    chk(q, {24'h0, c});
  endtask : expSt

  function automatic logic [31:0] ctl(input logic clr, input logic ae, input logic sta);
    ctl = 32'h0;
    ctl[tws_pkg::CTRL_INT_FLAG] = clr;
    ctl[tws_pkg::CTRL_ACK_EN] = ae;
    ctl[tws_pkg::CTRL_START_REQ] = sta;
    ctl[tws_pkg::CTRL_IF_EN] = 1'b1;
  endfunction : ctl

  task sendAddr(input logic [7:0] a, input logic e);
    i_mst.startC;
    sendByte(a, e);
  endtask : sendAddr

  task sendByte(input logic [7:0] d, input logic e);
    i_mst.xfer(d, 1'b1, rx, ack);
    chk(32'(ack), 32'(e));
  endtask : sendByte

  task readByte(input logic mAck, input logic [7:0] e);
    i_mst.xfer(8'hFF, mAck, rx, ack);
    chk(32'(rx), 32'(e));
  endtask : readByte

  initial begin
    #100000;
    fails++;
    finish_test;
  end

  // ==========================================================================
  // tests
  initial begin
    {psel, penable, pwrite, deepSleep, arbLost, rst_n, paddr, pwdata} = 46'h0;
    {fails, checked, starts} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(tws_pkg::ADDR_CTRL, 32'h0);
    rd(tws_pkg::ADDR_STATUS, 32'hF8);
    rd(tws_pkg::ADDR_DATA, 32'hFF);
    rd(tws_pkg::ADDR_OWN, 32'h0);
    wr(8'h10, 32'hFF);
    chk(32'(err), 32'h1);
    wr(tws_pkg::ADDR_OWN, 32'h55);
    rd(tws_pkg::ADDR_OWN, 32'h55);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    // own address write, data, stop, queued start; prescaler bits stay zero
    sendAddr(8'h54, 1'b0);
    expSt(tws_pkg::ST_RX_OWN);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    sendByte(8'hA5, 1'b0);
    expSt(tws_pkg::ST_RX_DATA);
    rd(tws_pkg::ADDR_DATA, 32'hA5);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    i_mst.stopC;
    expSt(tws_pkg::ST_STOP);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b1));
    repeat (20) @(posedge clk_sys);
    chk(32'(starts), 32'h1);
    // general call, acked then refused
    sendAddr(8'h00, 1'b0);
    expSt(tws_pkg::ST_RX_GC);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    sendByte(8'h11, 1'b0);
    expSt(tws_pkg::ST_GC_DATA);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
    sendByte(8'h22, 1'b1);
    expSt(tws_pkg::ST_GC_NACK);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    i_mst.stopC;
    rd(tws_pkg::ADDR_STATUS, 32'hF8);
    // transmit, then last byte acked by a greedy master
    sendAddr(8'h55, 1'b0);
    expSt(tws_pkg::ST_TX_OWN);
    wr(tws_pkg::ADDR_DATA, 32'h3C);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    readByte(1'b0, 8'h3C);
    expSt(tws_pkg::ST_TX_ACK);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0));
    wr(tws_pkg::ADDR_DATA, 32'hC3);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
    readByte(1'b0, 8'hC3);
    expSt(tws_pkg::ST_TX_LAST);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    readByte(1'b1, 8'hFF);
    i_mst.stopC;
    // isolated while acknowledge is off; then lost arbitration, own read, byte nacked by the master
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0));
    sendAddr(8'h54, 1'b1);
    i_mst.stopC;
    rd(tws_pkg::ADDR_STATUS, 32'hF8);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    arbLost <= 1'b1;
    sendAddr(8'h55, 1'b0);
    expSt(tws_pkg::ST_TX_OWN_AL);
    wr(tws_pkg::ADDR_DATA, 32'h96);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    arbLost <= 1'b0;
    readByte(1'b1, 8'h96);
    expSt(tws_pkg::ST_TX_NACK);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    i_mst.stopC;
    // general call ignored when its enable is off
    wr(tws_pkg::ADDR_OWN, 32'h54);
    sendAddr(8'h00, 1'b1);
    i_mst.stopC;
    wr(tws_pkg::ADDR_DATA, 32'h77);
    rd(tws_pkg::ADDR_CTRL, 32'h4C);
    wr(tws_pkg::ADDR_OWN, 32'h55);
    // wake from deep sleep; data register content not relied upon here
    deepSleep <= 1'b1;
    sendAddr(8'h54, 1'b0);
    expSt(tws_pkg::ST_RX_OWN);
    chk(32'(wakeReq), 32'h1);
    chk(32'(sclOe), 32'h1);
    deepSleep <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(32'(wakeReq), 32'h0);
    wr(tws_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0));
    i_mst.stopC;
    expSt(tws_pkg::ST_STOP);
    wr(tws_pkg::ADDR_CTRL, 32'hD5);
    rd(tws_pkg::ADDR_CTRL, 32'h4D);
    rd(tws_pkg::ADDR_STATUS, 32'hF8);
    finish_test;
  end
endmodule : two_wire_slave_state_control_tb

// >>> testbench/tws_bus_master.sv
`timescale 1ns/1ps
// ==========================================================================
// bus master model, open drain, both lines pulled up outside
module tws_bus_master (
  // resolved wire levels
  input  wire logic sclW,
  input  wire logic sdaW,
  // pull-downs
  output      logic sclLow,
  output      logic sdaLow
);
  logic tick;

  // quarter-period tick, unrelated in phase to the system clock
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    tick   = 1'b0;
    #1.3;
    forever #4 tick = ~tick;
  end

  task automatic step(input int n);
    repeat (n) @(posedge tick);
  endtask : step

  // a stretched clock gets one extra tick so the high level stays long enough
  task automatic sclHigh;
    sclLow <= 1'b0;
    step(1);
    if (!sclW) begin
      while (!sclW) step(1);
      step(1);
    end
    step(1);
  endtask : sclHigh

  task automatic startC;
    sdaLow <= 1'b1;
    step(2);
    sclLow <= 1'b1;
    step(1);
  endtask : startC

  task automatic stopC;
    sdaLow <= 1'b1;
    step(1);
    sclHigh;
    sdaLow <= 1'b0;
    step(2);
  endtask : stopC

  task automatic bitX(input logic b, output logic r);
    sdaLow <= !b;
    step(1);
    sclHigh;
    r = sdaW;
    sclLow <= 1'b1;
    step(1);
  endtask : bitX

  // msb first, ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitX(d[i], q[i]);
    bitX(ackOut, ack);
  endtask : xfer
endmodule : tws_bus_master

// >>> testbench/tws_slave_ctrl_chk.sv
`timescale 1ns/1ps
// ==========================================================================
// port checker for the slave controller
module tws_slave_ctrl_chk #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          rst_n,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // bus pins and system side
  input wire logic          sclIn,
  input wire logic          sclOut,
  input wire logic          sclOe,
  input wire logic          sdaIn,
  input wire logic          sdaOut,
  input wire logic          sdaOe,
  input wire logic          deepSleep,
  input wire logic          wakeReq,
  input wire logic          masterStart
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic mapped;
  logic clrWr;
  assign mapped = paddr[7:0] inside {tws_pkg::ADDR_CTRL, tws_pkg::ADDR_STATUS,
                                     tws_pkg::ADDR_DATA, tws_pkg::ADDR_OWN};
  assign clrWr  = psel && penable && pwrite && paddr[7:0] == tws_pkg::ADDR_CTRL
                  && pwdata[tws_pkg::CTRL_INT_FLAG];

  sequence heldClear;
    clrWr && sclOe;
  endsequence
  sequence sclSteady;
    sclIn [*3];
  endsequence

  // ==========================================================================
  // properties
  ready_high_a: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  open_drain_a: assert property (!sclOut && !sdaOut)
    else $error("bus pin driven high");
  stretch_hold_a: assert property (sclOe && !clrWr |=> sclOe)
    else $error("clock stretch dropped without a clear");
  stretch_release_a: assert property (heldClear |=> !sclOe [*2])
    else $error("clock stretch kept after a clear");
  sda_stable_a: assert property (sclSteady |-> $stable(sdaOe))
    else $error("data line moved while clock high");
  start_free_a: assert property (masterStart |-> sclIn && sdaIn ##1 !masterStart)
    else $error("start request issued on a busy bus");
  wake_cause_a: assert property ($rose(wakeReq) |-> $past(deepSleep))
    else $error("wake request outside sleep");
  wake_clear_a: assert property (!deepSleep |=> !wakeReq)
    else $error("wake request kept while awake");
endmodule : tws_slave_ctrl_chk

bind tws_slave_ctrl tws_slave_ctrl_chk #(.AW(AW)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .deepSleep(deepSleep), .wakeReq(wakeReq), .masterStart(masterStart)
);
